//--- dv/crb_master.sv
`timescale 1ns/1ps
`default_nettype none
module crb_master
  import crb_pkg::*;
(
  // Clock
  input wire logic clk_sys_i,
  // Request
  output logic req_valid_o,
  output logic [7:0] req_station_o,
  output logic [7:0] req_func_o,
  output logic [15:0] req_reg_o,
  output logic [7:0] req_qty_o,
  output logic [15:0] req_wdata_o,
  // Answer
  input wire logic rsp_valid_i,
  input wire logic rsp_reply_i,
  input wire logic [7:0] rsp_exc_code_i,
  input wire logic [15:0] rsp_rdata_i
);
  initial begin
    req_valid_o = 1'b0;
    req_station_o = 8'h00;
    req_func_o = 8'h00;
    req_reg_o = 16'h0000;
    req_qty_o = 8'h00;
    req_wdata_o = 16'h0000;
  end
  // One register access, held over the taking edge
  task automatic xfer(input logic [7:0] st, fn, input logic [15:0] rg, wd,
      input logic [7:0] qt, output logic v, rp, output logic [7:0] e,
      output logic [15:0] d);
    @(negedge clk_sys_i);
    req_valid_o = 1'b1;
    req_station_o = st;
    req_func_o = fn;
    req_reg_o = rg;
    req_qty_o = qt;
    req_wdata_o = wd;
    @(negedge clk_sys_i);
    v = rsp_valid_i;
    rp = rsp_reply_i;
    e = rsp_exc_code_i;
    d = rsp_rdata_i;
    // Released fields show inverted values
    req_valid_o = 1'b0;
    req_station_o = ~st;
    req_func_o = ~fn;
    req_reg_o = ~rg;
    req_qty_o = ~qt;
    req_wdata_o = ~wd;
  endtask : xfer
endmodule : crb_master
`default_nettype wire

//--- dv/tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin \
  mismatches++; $display("MISMATCH %s exp %0h got %0h", nm, ex, got); end end
module tb;
  import crb_pkg::*;
  logic clk_sys_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic in_a_i = 1'b0, in_b_i = 1'b0, aux_i = 1'b0, clr_t = 1'b0;
  logic clr_b = 1'b0, clr_l = 1'b0, rst_apply = 1'b0;
  logic [3:0] hit = 4'h0, relay;
  logic rv, rr, rx, qv;
  logic [7:0] rs, rf, rq, rc;
  logic [15:0] rg, rw, rd;
  logic [2:0] point;
  logic [31:0] count, shown;
  int mismatches = 0;
  int num_checks = 0;
  always #5 clk_sys_i = ~clk_sys_i;
  crb_master mst_u (.clk_sys_i(clk_sys_i), .req_valid_o(qv),
    .req_station_o(rs), .req_func_o(rf), .req_reg_o(rg), .req_qty_o(rq),
    .req_wdata_o(rw), .rsp_valid_i(rv), .rsp_reply_i(rr),
    .rsp_exc_code_i(rc), .rsp_rdata_i(rd));
  crb_top #(.FAST_CYC_P(4), .SLOW_CYC_P(90)) dut_u (.clk_sys_i(clk_sys_i),
    .rst_b_i(rst_b_i), .req_valid_i(qv), .req_station_i(rs),
    .req_func_i(rf), .req_reg_i(rg), .req_qty_i(rq), .req_wdata_i(rw),
    .rsp_valid_o(rv), .rsp_reply_o(rr), .rsp_exc_o(rx),
    .rsp_exc_code_o(rc), .rsp_rdata_o(rd), .in_a_i(in_a_i),
    .in_b_i(in_b_i), .aux_i(aux_i), .clr_terminal_i(clr_t),
    .clr_button_i(clr_b), .clr_link_i(clr_l), .restart_i(rst_apply),
    .relay_hit_i(hit), .relay_o(relay), .point_o(point), .count_o(count),
    .shown_o(shown));
  function automatic logic [31:0] exp_shown(int c, int m, int b);
    return 32'(c * m + b);
  endfunction : exp_shown
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_sim
  task automatic acc(input logic [7:0] st, fn, input logic [15:0] a, wd,
      input logic [7:0] qt, ex, input logic [15:0] ed);
    logic v, p;
    logic [7:0] e;
    logic [15:0] d;
    mst_u.xfer(st, fn, a, wd, qt, v, p, e, d);
    `CHK("valid", 1'b1, v)
    `CHK("reply", st != 8'h00, p)
    `CHK("exc", ex, e)
    `CHK("rdata", ed, d)
    `CHK("exc_flag", ex != 8'h00, rx)
  endtask : acc
  task automatic wr(input logic [15:0] a, wd, input logic [7:0] ex);
    acc(8'h01, FN_WR1, a, wd, 8'h01, ex, ex == 8'h00 ? wd : 16'h0000);
  endtask : wr
  task automatic pulse(input logic a, b);
    @(negedge clk_sys_i);
    in_a_i = a;
    in_b_i = b;
    repeat (6) @(negedge clk_sys_i);
    in_a_i = 1'b0;
    in_b_i = 1'b0;
    repeat (6) @(negedge clk_sys_i);
  endtask : pulse
  task automatic quad(input int n);
    for (int i = 0; i < n; i++) begin
      {in_a_i, in_b_i} = {~i[1], i[0] ^ i[1]};
      repeat (6) @(negedge clk_sys_i);
    end
  endtask : quad
  initial begin
    repeat (60000) @(posedge clk_sys_i);
    mismatches++;
    end_sim();
  end
  initial begin
    logic [15:0] adr [7];
    logic [15:0] mx [7];
    logic [15:0] w;
    logic [31:0] u;
    logic v, p;
    logic [7:0] e;
    int m, b;
    adr = '{ADR_AUX, ADR_CLR, ADR_ACLR, ADR_FILT, ADR_FUNC, ADR_POINT,
      ADR_APPLY};
    mx = '{16'h0002, 16'h0003, 16'h0002, 16'h0009, 16'h0003, 16'h0005,
      16'h0001};
    void'($urandom(32'haf6e));
    repeat (20) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    rst_b_i = 1'b1;
    acc(8'h01, FN_READ, ADR_IDENT, 16'h0, 8'h01, 8'h00, 16'h5a3c);
    wr(ADR_IDENT, 16'h0001, EXC_ADDR);
    wr(ADR_TASK, 16'h0001, EXC_ADDR);
    acc(8'h01, FN_READ, 16'h0030, 16'h0, 8'h01, EXC_ADDR, 16'h0);
    acc(8'h01, 8'h2b, ADR_RELAY, 16'h0, 8'h01, EXC_FUNC, 16'h0);
    acc(8'h01, FN_READ, ADR_RELAY, 16'h0, 8'h11, EXC_VALUE, 16'h0);
    repeat (4) begin
      w = 16'($urandom());
      wr(ADR_RELAY, w, 8'h00);
      `CHK("relay", w[3:0], relay)
      acc(8'h01, FN_READ, ADR_RELAY, 0, 8'h01, 0, {12'h0, w[3:0]});
    end
    wr(ADR_RELAY, 16'h0000, 8'h00);
    @(negedge clk_sys_i) hit = 4'h4;
    @(negedge clk_sys_i) hit = 4'h0;
    `CHK("relay_hit", 4'h4, relay)
    mst_u.xfer(8'h01, FN_READ, ADR_TASK, 0, 8'h01, v, p, e, w);
    `CHK("task", 1'b1, w[2])
    for (int i = 0; i < 7; i++) begin
      wr(adr[i], mx[i] + 16'h1, EXC_VALUE);
      w = 16'($urandom_range(int'(mx[i])));
      wr(adr[i], w, 8'h00);
      acc(8'h01, FN_READ, adr[i], 0, 8'h01, 0, w);
      wr(adr[i], 16'h0000, 8'h00);
    end
    wr(ADR_POINT, 16'h0005, 8'h00);
    repeat (3) @(negedge clk_sys_i);
    `CHK("point", 3'h5, point)
    wr(ADR_APPLY, 16'h0001, 8'h00);
    wr(ADR_POINT, 16'h0003, 8'h00);
    repeat (3) @(negedge clk_sys_i);
    `CHK("point_held", 3'h5, point)
    rst_apply = 1'b1;
    @(negedge clk_sys_i) rst_apply = 1'b0;
    repeat (3) @(negedge clk_sys_i);
    `CHK("point_restart", 3'h3, point)
    wr(ADR_APPLY, 16'h0000, 8'h00);
    wr(ADR_STATION, 16'h00c8, EXC_VALUE);
    wr(ADR_STATION, 16'h0002, 8'h00);
    mst_u.xfer(8'h01, FN_READ, ADR_IDENT, 0, 8'h01, v, p, e, w);
    `CHK("foreign", 1'b0, v)
    acc(8'h02, FN_WR1, ADR_STATION, 16'h1, 8'h01, 8'h0, 16'h1);
    m = -99999;
    u = m;
    wr(ADR_MUL_HI, u[31:16], 8'h00);
    wr(ADR_MUL_LO, u[15:0], 8'h00);
    wr(ADR_MUL_HI, 16'h000f, 8'h00);
    wr(ADR_MUL_LO, 16'h4240, EXC_VALUE);
    acc(8'h01, FN_READ, ADR_MUL_HI, 0, 8'h01, 0, u[31:16]);
    acc(8'h01, FN_READ, ADR_MUL_LO, 0, 8'h01, 0, u[15:0]);
    wr(ADR_DIV_HI, 16'h0000, 8'h00);
    wr(ADR_DIV_LO, 16'h0000, EXC_VALUE);
    wr(ADR_DIV_LO, 16'h0002, 8'h00);
    b = int'($urandom_range(1999998)) - 999999;
    u = b;
    wr(ADR_BIAS_HI, u[31:16], 8'h00);
    wr(ADR_BIAS_LO, u[15:0], 8'h00);
    clr_l = 1'b1;
    @(negedge clk_sys_i) clr_l = 1'b0;
    repeat (4) pulse(1'b1, 1'b0);
    `CHK("count_add", 32'd2, count)
    `CHK("shown", exp_shown(2, m, b), shown)
    wr(ADR_FUNC, 16'h0001, 8'h00);
    pulse(1'b1, 1'b1);
    repeat (4) pulse(1'b0, 1'b1);
    `CHK("count_sub", 32'd0, count)
    `CHK("shown_bias", exp_shown(0, m, b), shown)
    repeat (2) pulse(1'b1, 1'b0);
    wr(ADR_CLR, 16'h0003, 8'h00);
    clr_b = 1'b1;
    repeat (3) @(negedge clk_sys_i);
    clr_b = 1'b0;
    `CHK("no_button_clear", 32'd1, count)
    clr_l = 1'b1;
    repeat (3) @(negedge clk_sys_i);
    clr_l = 1'b0;
    `CHK("link_clear", 32'd0, count)
    wr(ADR_FUNC, 16'h0003, 8'h00);
    quad(8);
    `CHK("quad_x4", 32'd4, count)
    wr(ADR_FUNC, 16'h0002, 8'h00);
    wr(ADR_AUX, 16'h0001, 8'h00);
    aux_i = 1'b1;
    quad(8);
    `CHK("aux_dir", 32'd3, count)
    wr(ADR_AUX, 16'h0002, 8'h00);
    quad(8);
    aux_i = 1'b0;
    `CHK("aux_hold", 32'd3, count)
    wr(ADR_FILT, 16'h0001, 8'h00);
    quad(8);
    `CHK("filter", 32'd3, count)
    wr(ADR_ACLR, 16'h0001, 8'h00);
    @(negedge clk_sys_i) hit = 4'h1;
    @(negedge clk_sys_i) hit = 4'h0;
    `CHK("auto_clear", 32'd0, count)
    acc(8'h00, FN_WR1, ADR_RELAY, 16'h0009, 8'h01, 8'h00, 16'h0009);
    `CHK("broadcast", 4'h9, relay)
    wr(ADR_PERMIT, 16'h0000, 8'h00);
    wr(ADR_RELAY, 16'h0006, EXC_FUNC);
    `CHK("locked", 4'h9, relay)
    end_sim();
  end
endmodule : tb
`default_nettype wire

//--- hw/crb_counter.sv
`timescale 1ns/1ps
`default_nettype none
module crb_counter
  import crb_pkg::*;
#(
  parameter int unsigned FAST_CYC_P = FAST_CYC,
  parameter int unsigned SLOW_CYC_P = SLOW_CYC
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  // Counting inputs
  input wire logic in_a_i,
  input wire logic in_b_i,
  input wire logic aux_i,
  input wire logic hit_r1_i,
  input wire logic clear_i,
  // Settings
  input wire logic [1:0] aux_mode_i,
  input wire logic [1:0] func_i,
  input wire logic [3:0] filt_i,
  input wire logic [1:0] aclr_i,
  input wire logic [31:0] div_i,
  input wire logic [31:0] mul_i,
  input wire logic [31:0] bias_i,
  // Results
  output logic [31:0] count_o,
  output logic [31:0] shown_o
);

  localparam int unsigned MAXC = (FAST_CYC_P > SLOW_CYC_P) ? FAST_CYC_P
                                                            : SLOW_CYC_P;
  localparam int LW = $clog2(MAXC) + 1;

  if (FAST_CYC_P < 1 || SLOW_CYC_P < 9) begin : g_chk
    $error("Filter cycle counts too small");
  end

  typedef struct packed {
    logic a;
    logic b;
    logic [LW-1:0] lock;
    logic [31:0] pre;
    logic [31:0] main;
    logic [31:0] shown;
  } crb_cnt_s;

  crb_cnt_s q;
  crb_cnt_s d;
  logic step;
  logic up;
  logic clear;
  logic [31:0] pre;

  function automatic logic [LW-1:0] lock_len(input logic [3:0] f);
    int unsigned c;
    c = FAST_CYC_P;
    if (f != 4'h0 && f <= 4'h9) c = SLOW_CYC_P / int'(f);
    return LW'(c - 1);
  endfunction : lock_len

  always_comb begin
    d = q;
    d.a = in_a_i;
    d.b = in_b_i;
    step = 1'b0;
    up = 1'b1;
    clear = clear_i;
    pre = q.pre;
    unique case (func_i)
      FUNC_A_PLUS_B: step = (in_a_i & ~q.a) | (in_b_i & ~q.b); // R9
      FUNC_A_MINUS_B: begin // R9
        step = (in_a_i & ~q.a) ^ (in_b_i & ~q.b);
        up = in_a_i & ~q.a;
      end
      FUNC_QUAD_X1: begin // R10
        step = in_a_i & ~q.a;
        up = ~in_b_i;
      end
      FUNC_QUAD_X4: begin // R10
        step = (in_a_i ^ q.a) ^ (in_b_i ^ q.b);
        up = in_a_i ^ q.b;
      end
    endcase
    if (aux_mode_i == AUX_DIRECTION && aux_i) up = ~up; // R5
    if (aux_mode_i == AUX_HOLD && aux_i) step = 1'b0; // R5
    if (q.lock != '0) begin // R8
      d.lock = q.lock - 1'b1;
      step = 1'b0;
    end else if (step) begin
      d.lock = lock_len(filt_i); // R8
    end
    if (q.pre >= div_i) pre = 32'h0000_0000;
    if (aclr_i == AUTOCLEAR_AT_RELAY1_SETPOINT && hit_r1_i) clear = 1'b1; // R7
    if (aclr_i == AUTOCLEAR_BELOW_ZERO && $signed(q.main) < 0) clear = 1'b1; // R7 R18
    d.pre = pre;
    if (clear) begin
      d.pre = 32'h0000_0000;
      d.main = 32'h0000_0000;
    end else if (step && up) begin
      if (pre + 32'h1 >= div_i) begin // R11
        d.pre = 32'h0000_0000;
        d.main = q.main + 32'h1;
      end else begin
        d.pre = pre + 32'h1;
      end
    end else if (step) begin
      if (pre == 32'h0) begin // R11
        d.pre = div_i - 32'h1;
        d.main = q.main - 32'h1;
      end else begin
        d.pre = pre - 32'h1;
      end
    end
    d.shown = ($signed(q.main) * $signed(mul_i)) + $signed(bias_i); // R12 R18
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign count_o = q.main;
  assign shown_o = q.shown;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);

  property p_pre_bound;
    (div_i == $past(div_i)) |-> (q.pre < div_i);
  endproperty
  a_pre_bound: assert property (p_pre_bound) else $error("Precount at divider"); // R11

  property p_below_zero;
    (aclr_i == AUTOCLEAR_BELOW_ZERO && $signed(q.main) < 0)
      |=> (q.main == 32'h0);
  endproperty
  a_below_zero: assert property (p_below_zero) else $error("Negative kept"); // R7

  property p_cv_wrap;
    (q.main != $past(q.main)) && (div_i > 32'h1);
  endproperty
  c_cv_wrap: cover property (p_cv_wrap);

endmodule : crb_counter
`default_nettype wire

//--- hw/crb_top.sv
// Function
// R1 - Relay state reads in bits 0 to 3
// R2 - Relay write uses bits 0 to 3 only
// R3 - Task bit shows relay has fired
// R4 - Settings apply at once or on restart
// R5 - Aux input off, direction or hold
// R6 - Clear sources chosen by clear mode
// R7 - Auto-clear off, relay one or below zero
// R8 - Input rate limit codes 0 to 9
// R9 - Code 0 adds, code 1 subtracts inputs
// R10 - Quadrature counting per cycle or quarter
// R11 - Count once per divider events
// R12 - Shown value is scaled count, multiplier range
// R13 - High word at lower address
// R14 - Display bias within plus minus 999999
// R15 - Decimal places 0 to 5
// R16 - Fixed readable identification code
// R17 - Read 03h, write 06h or 10h, 16 max
// R18 - Signed values in two's complement
// R19 - Broadcasts executed without reply
// R20 - Write permission gates link writes
// R21 - Station 0 to 199, own address only
// R22 - Bad writes refused with exception
`timescale 1ns/1ps
`default_nettype none
module crb_top
  import crb_pkg::*;
#(
  parameter int unsigned FAST_CYC_P = FAST_CYC,
  parameter int unsigned SLOW_CYC_P = SLOW_CYC,
  parameter logic [15:0] ID_CODE = 16'h5a3c // Arbitrary value
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  // Decoded link request, one register per request
  input wire logic req_valid_i,
  input wire logic [7:0] req_station_i,
  input wire logic [7:0] req_func_i,
  input wire logic [15:0] req_reg_i,
  input wire logic [7:0] req_qty_i,
  input wire logic [15:0] req_wdata_i,
  // Link answer
  output logic rsp_valid_o,
  output logic rsp_reply_o,
  output logic rsp_exc_o,
  output logic [7:0] rsp_exc_code_o,
  output logic [15:0] rsp_rdata_o,
  // Counting and clearing inputs
  input wire logic in_a_i,
  input wire logic in_b_i,
  input wire logic aux_i,
  input wire logic clr_terminal_i,
  input wire logic clr_button_i,
  input wire logic clr_link_i,
  input wire logic restart_i,
  input wire logic [3:0] relay_hit_i,
  // Results
  output logic [3:0] relay_o,
  output logic [2:0] point_o,
  output logic [31:0] count_o,
  output logic [31:0] shown_o
);

  typedef struct packed {
    crb_cfg_s sto;
    crb_cfg_s act;
    logic [3:0] relay;
    logic [3:0] fired;
    logic apply;
    logic [7:0] station;
    logic permit;
    logic [15:0] pend_hi;
    logic load;
    logic rsp_valid;
    logic rsp_reply;
    logic rsp_exc;
    logic [7:0] rsp_code;
    logic [15:0] rsp_data;
  } crb_top_s;

  localparam crb_top_s TOP_RST = '{sto: CFG_RST, act: CFG_RST,
    relay: 4'h0, fired: 4'h0, apply: RST_APPLY, station: RST_STATION,
    permit: RST_PERMIT, pend_hi: 16'h0000, load: 1'b1, rsp_valid: 1'b0,
    rsp_reply: 1'b0, rsp_exc: 1'b0, rsp_code: 8'h00,
    rsp_data: 16'h0000};

  crb_top_s q;
  crb_top_s d;
  logic own_req;
  logic bcast_req;
  logic clear_now;
  logic [16:0] rd;
  logic [31:0] pair;
  logic is_rd;
  logic is_wr;
  logic bad_adr;
  logic bad_val;
  logic [3:0] wr_low;

  function automatic logic in_span(input logic [31:0] v, input int lo,
                                   input int hi);
    return ($signed(v) >= lo) && ($signed(v) <= hi);
  endfunction : in_span

  function automatic logic [16:0] rd_word(input logic [15:0] a,
                                          input crb_top_s s,
                                          input logic [15:0] id);
    logic [16:0] r;
    r = 17'h0_0000;
    case (a)
      ADR_RELAY: r = {1'b1, 12'h000, s.relay}; // R1
      ADR_TASK: r = {1'b1, 12'h000, s.fired}; // R3
      ADR_APPLY: r = {1'b1, 15'h0000, s.apply};
      ADR_AUX: r = {1'b1, 14'h0000, s.sto.aux};
      ADR_CLR: r = {1'b1, 14'h0000, s.sto.clr};
      ADR_ACLR: r = {1'b1, 14'h0000, s.sto.aclr};
      ADR_FILT: r = {1'b1, 12'h000, s.sto.filt};
      ADR_FUNC: r = {1'b1, 14'h0000, s.sto.func};
      ADR_MUL_HI: r = {1'b1, s.sto.mul[31:16]}; // R13
      ADR_MUL_LO: r = {1'b1, s.sto.mul[15:0]};
      ADR_DIV_HI: r = {1'b1, s.sto.div[31:16]}; // R13
      ADR_DIV_LO: r = {1'b1, s.sto.div[15:0]};
      ADR_BIAS_HI: r = {1'b1, s.sto.bias[31:16]}; // R13
      ADR_BIAS_LO: r = {1'b1, s.sto.bias[15:0]};
      ADR_POINT: r = {1'b1, 13'h0000, s.sto.point};
      ADR_STATION: r = {1'b1, 8'h00, s.station};
      ADR_IDENT: r = {1'b1, id}; // R16
      ADR_PERMIT: r = {1'b1, 15'h0000, s.permit};
      default: r = 17'h0_0000;
    endcase
    return r;
  endfunction : rd_word

  assign own_req = req_valid_i && (req_station_i == q.station); // R21
  assign bcast_req = req_valid_i && (req_station_i == BROADCAST);
  assign wr_low = req_wdata_i[3:0];

  always_comb begin
    d = q;
    rd = rd_word(req_reg_i, q, ID_CODE);
    pair = {q.pend_hi, req_wdata_i}; // R13
    is_rd = (req_func_i == FN_READ);
    is_wr = (req_func_i == FN_WR1) || (req_func_i == FN_WRN);
    bad_adr = 1'b0;
    bad_val = 1'b0;
    clear_now = 1'b0;
    d.load = 1'b0;
    d.rsp_valid = 1'b0;
    d.rsp_reply = 1'b0;
    d.rsp_exc = 1'b0;
    d.rsp_code = 8'h00;
    d.rsp_data = 16'h0000;
    d.relay = q.relay | relay_hit_i;
    if (own_req || bcast_req) begin
      d.rsp_valid = 1'b1;
      d.rsp_reply = own_req; // R19
      if (!is_rd && !is_wr) begin // R17
        d.rsp_exc = 1'b1;
        d.rsp_code = EXC_FUNC;
      end else if (req_func_i != FN_WR1 &&
                   (req_qty_i == 8'h00 || req_qty_i > MAX_GROUP)) begin // R17
        d.rsp_exc = 1'b1;
        d.rsp_code = EXC_VALUE;
      end else if (is_rd) begin
        if (rd[16]) begin
          d.rsp_data = rd[15:0];
        end else begin
          bad_adr = 1'b1;
        end
      end else if (!q.permit) begin // R20
        d.rsp_exc = 1'b1;
        d.rsp_code = EXC_FUNC;
      end else begin
        d.rsp_data = req_wdata_i;
        case (req_reg_i)
          ADR_RELAY: d.relay = wr_low | relay_hit_i; // R2
          ADR_APPLY: begin
            if (req_wdata_i <= FLAG_MAX) d.apply = req_wdata_i[0]; // R4
            else bad_val = 1'b1;
          end
          ADR_AUX: begin
            if (req_wdata_i <= AUX_MAX) d.sto.aux = req_wdata_i[1:0]; // R5
            else bad_val = 1'b1;
          end
          ADR_CLR: begin
            if (req_wdata_i <= CLR_MAX) d.sto.clr = req_wdata_i[1:0]; // R6
            else bad_val = 1'b1;
          end
          ADR_ACLR: begin
            if (req_wdata_i <= ACLR_MAX) d.sto.aclr = req_wdata_i[1:0]; // R7
            else bad_val = 1'b1;
          end
          ADR_FILT: begin
            if (req_wdata_i <= FILT_MAX) d.sto.filt = req_wdata_i[3:0]; // R8
            else bad_val = 1'b1;
          end
          ADR_FUNC: begin
            if (req_wdata_i <= FUNC_MAX) d.sto.func = req_wdata_i[1:0]; // R9
            else bad_val = 1'b1;
          end
          ADR_MUL_HI, ADR_DIV_HI, ADR_BIAS_HI: d.pend_hi = req_wdata_i; // R13
          ADR_MUL_LO: begin
            if (in_span(pair, MUL_MIN, MUL_MAX)) d.sto.mul = pair; // R12 R18
            else bad_val = 1'b1;
          end
          ADR_DIV_LO: begin
            if (in_span(pair, DIV_MIN, DIV_MAX)) d.sto.div = pair; // R11
            else bad_val = 1'b1;
          end
          ADR_BIAS_LO: begin
            if (in_span(pair, BIAS_MIN, BIAS_MAX)) d.sto.bias = pair; // R14
            else bad_val = 1'b1;
          end
          ADR_POINT: begin
            if (req_wdata_i <= POINT_MAX) d.sto.point = req_wdata_i[2:0]; // R15
            else bad_val = 1'b1;
          end
          ADR_STATION: begin
            if (req_wdata_i <= STATION_MAX) d.station = req_wdata_i[7:0]; // R21
            else bad_val = 1'b1;
          end
          ADR_PERMIT: begin
            if (req_wdata_i <= FLAG_MAX) d.permit = req_wdata_i[0]; // R20
            else bad_val = 1'b1;
          end
          default: bad_adr = 1'b1; // R22
        endcase
      end
      if (bad_adr) begin // R22
        d.rsp_exc = 1'b1;
        d.rsp_code = EXC_ADDR;
        d.rsp_data = 16'h0000;
      end else if (bad_val) begin // R22
        d.rsp_exc = 1'b1;
        d.rsp_code = EXC_VALUE;
        d.rsp_data = 16'h0000;
      end
    end
    unique case (q.act.clr)
      CLEAR_BY_ALL: clear_now = clr_link_i | clr_terminal_i | clr_button_i; // R6
      CLEAR_BY_TERMINAL: clear_now = clr_link_i | clr_terminal_i; // R6
      CLEAR_BY_BUTTON: clear_now = clr_link_i | clr_button_i; // R6
      CLEAR_BY_LINK: clear_now = clr_link_i; // R6
    endcase
    d.fired = (clear_now ? 4'h0 : q.fired) | (d.relay & ~q.relay) | relay_hit_i; // R3
    if (q.apply == APPLY_AT_ONCE || q.load || restart_i) d.act = d.sto; // R4
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      q <= TOP_RST;
    end else begin
      q <= d;
    end
  end

  assign rsp_valid_o = q.rsp_valid;
  assign rsp_reply_o = q.rsp_reply;
  assign rsp_exc_o = q.rsp_exc;
  assign rsp_exc_code_o = q.rsp_code;
  assign rsp_rdata_o = q.rsp_data;
  assign relay_o = q.relay;
  assign point_o = q.act.point; // R15

  crb_counter #(
    .FAST_CYC_P(FAST_CYC_P),
    .SLOW_CYC_P(SLOW_CYC_P)
  ) u_counter (
    .clk_sys_i(clk_sys_i),
    .rst_b_i(rst_b_i),
    .in_a_i(in_a_i),
    .in_b_i(in_b_i),
    .aux_i(aux_i),
    .hit_r1_i(relay_hit_i[0]),
    .clear_i(clear_now),
    .aux_mode_i(q.act.aux),
    .func_i(q.act.func),
    .filt_i(q.act.filt),
    .aclr_i(q.act.aclr),
    .div_i(q.act.div),
    .mul_i(q.act.mul),
    .bias_i(q.act.bias),
    .count_o(count_o),
    .shown_o(shown_o)
  );

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);

  property p_relay_wr;
    (own_req && req_func_i == FN_WR1 && req_reg_i == ADR_RELAY && q.permit &&
     relay_hit_i == 4'h0) |=> (relay_o == $past(wr_low));
  endproperty
  a_relay_wr: assert property (p_relay_wr) else $error("Relay write lost"); // R2

  property p_relay_rd;
    (own_req && req_func_i == FN_READ && req_reg_i == ADR_RELAY &&
     req_qty_i == 8'h01) |=> (rsp_valid_o && !rsp_exc_o &&
     rsp_rdata_o == {12'h000, $past(relay_o)});
  endproperty
  a_relay_rd: assert property (p_relay_rd) else $error("Relay read wrong"); // R1

  property p_fired;
    ($rose(relay_o[0]) && !$past(clear_now)) |-> q.fired[0];
  endproperty
  a_fired: assert property (p_fired) else $error("Task bit not set"); // R3

  property p_ident;
    (own_req && req_func_i == FN_READ && req_reg_i == ADR_IDENT &&
     req_qty_i == 8'h01) |=> (rsp_rdata_o == ID_CODE && rsp_reply_o);
  endproperty
  a_ident: assert property (p_ident) else $error("Identity read wrong"); // R16

  property p_permit;
    (own_req && req_func_i == FN_WR1 && !q.permit)
      |=> (rsp_exc_o && rsp_exc_code_o == EXC_FUNC &&
           relay_o == ($past(relay_o) | $past(relay_hit_i)));
  endproperty
  a_permit: assert property (p_permit) else $error("Write not gated"); // R20
  property p_foreign;
    (req_valid_i && req_station_i != q.station &&
     req_station_i != BROADCAST) |=> !rsp_valid_o;
  endproperty
  a_foreign: assert property (p_foreign) else $error("Foreign answered"); // R21

  property p_bcast;
    bcast_req |=> (rsp_valid_o && !rsp_reply_o);
  endproperty
  a_bcast: assert property (p_bcast) else $error("Broadcast replied"); // R19

  property p_filt_range;
    (own_req && req_func_i == FN_WR1 && req_reg_i == ADR_FILT && q.permit &&
     req_wdata_i > FILT_MAX) |=> (rsp_exc_o && rsp_exc_code_o == EXC_VALUE
     && q.sto.filt == $past(q.sto.filt));
  endproperty
  a_filt_range: assert property (p_filt_range) else $error("Bad value kept"); // R22

  property p_group;
    (own_req && req_func_i == FN_READ && req_qty_i > MAX_GROUP)
      |=> (rsp_exc_o && rsp_exc_code_o == EXC_VALUE);
  endproperty
  a_group: assert property (p_group) else $error("Oversize group taken"); // R17

  property p_apply;
    (q.apply == APPLY_AT_ONCE && !restart_i) |=> (q.act == q.sto);
  endproperty
  a_apply: assert property (p_apply) else $error("Setting not applied"); // R4

  property p_pair;
    (own_req && req_func_i == FN_WR1 && req_reg_i == ADR_DIV_LO && q.permit
     && in_span(pair, DIV_MIN, DIV_MAX))
      |=> (q.sto.div[31:16] == $past(q.pend_hi) && !rsp_exc_o);
  endproperty
  a_pair: assert property (p_pair) else $error("Word pairing wrong"); // R13

  property p_cv_relay;
    own_req && req_func_i == FN_WR1 && req_reg_i == ADR_RELAY ##1 rsp_valid_o;
  endproperty
  c_cv_relay: cover property (p_cv_relay);

  property p_cv_bcast;
    bcast_req && is_wr ##1 rsp_valid_o && !rsp_reply_o;
  endproperty
  c_cv_bcast: cover property (p_cv_bcast);

  property p_cv_exc;
    rsp_exc_o && rsp_exc_code_o == EXC_VALUE;
  endproperty
  c_cv_exc: cover property (p_cv_exc);

endmodule : crb_top
`default_nettype wire

//--- inc/crb_pkg.sv
`default_nettype none
package crb_pkg;

  // Clock and input rate limits
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned FILT_FAST_HZ = 10_000;
  localparam int unsigned FILT_STEP_HZ = 10;
  localparam int unsigned FAST_CYC = CLK_HZ / FILT_FAST_HZ;
  localparam int unsigned SLOW_CYC = CLK_HZ / FILT_STEP_HZ;

  // Register offsets
  localparam logic [15:0] ADR_RELAY = 16'h0008;
  localparam logic [15:0] ADR_TASK = 16'h0009;
  localparam logic [15:0] ADR_APPLY = 16'h0010;
  localparam logic [15:0] ADR_AUX = 16'h0011;
  localparam logic [15:0] ADR_CLR = 16'h0012;
  localparam logic [15:0] ADR_ACLR = 16'h0013;
  localparam logic [15:0] ADR_FILT = 16'h0014;
  localparam logic [15:0] ADR_FUNC = 16'h0015;
  localparam logic [15:0] ADR_MUL_HI = 16'h0016;
  localparam logic [15:0] ADR_MUL_LO = 16'h0017;
  localparam logic [15:0] ADR_DIV_HI = 16'h0018;
  localparam logic [15:0] ADR_DIV_LO = 16'h0019;
  localparam logic [15:0] ADR_BIAS_HI = 16'h001a;
  localparam logic [15:0] ADR_BIAS_LO = 16'h001b;
  localparam logic [15:0] ADR_POINT = 16'h001c;
  localparam logic [15:0] ADR_STATION = 16'h0020;
  localparam logic [15:0] ADR_IDENT = 16'h0021;
  localparam logic [15:0] ADR_PERMIT = 16'h0023;

  // Link function and exception codes
  localparam logic [7:0] FN_READ = 8'h03;
  localparam logic [7:0] FN_WR1 = 8'h06;
  localparam logic [7:0] FN_WRN = 8'h10;
  localparam logic [7:0] EXC_FUNC = 8'h01;
  localparam logic [7:0] EXC_ADDR = 8'h02;
  localparam logic [7:0] EXC_VALUE = 8'h03;
  localparam logic [7:0] MAX_GROUP = 8'h10;
  localparam logic [7:0] BROADCAST = 8'h00;

  // Field ranges
  localparam logic [15:0] FLAG_MAX = 16'h0001;
  localparam logic [15:0] AUX_MAX = 16'h0002;
  localparam logic [15:0] CLR_MAX = 16'h0003;
  localparam logic [15:0] ACLR_MAX = 16'h0002;
  localparam logic [15:0] FILT_MAX = 16'h0009;
  localparam logic [15:0] FUNC_MAX = 16'h0003;
  localparam logic [15:0] POINT_MAX = 16'h0005;
  localparam logic [15:0] STATION_MAX = 16'h00c7;
  localparam int MUL_MIN = -99999;
  localparam int MUL_MAX = 999999;
  localparam int DIV_MIN = 1;
  localparam int DIV_MAX = 999999;
  localparam int BIAS_MIN = -999999;
  localparam int BIAS_MAX = 999999;

  // Modes
  typedef enum logic {APPLY_AT_ONCE = 1'b0, APPLY_ON_RESTART = 1'b1} crb_apply_e;
  typedef enum logic [1:0] {
    AUX_INPUT_OFF = 2'b00, AUX_DIRECTION = 2'b01, AUX_HOLD = 2'b10
  } crb_aux_e;
  typedef enum logic [1:0] {
    CLEAR_BY_ALL = 2'b00, CLEAR_BY_TERMINAL = 2'b01,
    CLEAR_BY_BUTTON = 2'b10, CLEAR_BY_LINK = 2'b11
  } crb_clr_e;
  typedef enum logic [1:0] {
    AUTOCLEAR_OFF = 2'b00, AUTOCLEAR_AT_RELAY1_SETPOINT = 2'b01,
    AUTOCLEAR_BELOW_ZERO = 2'b10
  } crb_aclr_e;
  typedef enum logic [1:0] {
    FUNC_A_PLUS_B = 2'b00, FUNC_A_MINUS_B = 2'b01,
    FUNC_QUAD_X1 = 2'b10, FUNC_QUAD_X4 = 2'b11
  } crb_func_e;

  // Counting settings
  typedef struct packed {
    logic [1:0] aux;
    logic [1:0] clr;
    logic [1:0] aclr;
    logic [3:0] filt;
    logic [1:0] func;
    logic [2:0] point;
    logic [31:0] mul;
    logic [31:0] div;
    logic [31:0] bias;
  } crb_cfg_s;

  // Values after reset
  localparam crb_cfg_s CFG_RST = '{aux: 2'h0, clr: 2'h0, aclr: 2'h0,
    filt: 4'h0, func: 2'h0, point: 3'h0, mul: 32'h0000_0001,
    div: 32'h0000_0001, bias: 32'h0000_0000};
  localparam logic RST_APPLY = 1'b0;
  localparam logic [7:0] RST_STATION = 8'h01;
  localparam logic RST_PERMIT = 1'b1;

endpackage : crb_pkg
`default_nettype wire
